// [hdl/pcsia_core.sv]
// pcsia_core: program counter, circular return stack and indirect
// data addressing of an 8-bit core, with the data file behind them.
// assumes the decoder and interrupt logic run on clk and raise one
// request per cycle; register port strobes are one cycle long.
//
// Functional notes
// - program counter is 13 bits wide
// - low byte readable/writable, upper bits from latch
// - any reset clears program counter
// - low byte write loads latch bits 4:0
// - jump/call: 11 target bits, latch 4:3
// - eight 13-bit stack entries, pointer hidden
// - call or interrupt pushes program counter
// - any return pops all 13 bits
// - push and pop leave latch untouched
// - stack wraps, ninth push overwrites first
// - no stack overflow or underflow flag
// - 8K words, 2K pages for branches
// - window has no storage, accesses pointer target
// - window selecting itself reads 00h
// - window selecting itself writes nothing
// - indirect address is bank bit plus pointer
//
// Chosen here: strobed register access and the register addresses.
`default_nettype none

module pcsia_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // requests from decoder and interrupt logic
  input  wire logic        fetch,
  input  wire logic        jump_req,
  input  wire logic        call_req,
  input  wire logic        ret_req,
  input  wire logic        int_req,
  input  wire logic [10:0] branch_target,
  input  wire logic [12:0] int_vector,
  // data file register port
  input  wire logic [8:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata_q,
  // program counter to fetch logic
  output var  logic [12:0] pc_q
);

  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // the window sits at the same offset in every bank
  function automatic logic is_window(input logic [8:0] a);
    is_window = (a[6:0] == pcsia_pkg::OFS_WINDOW);
  endfunction : is_window

  // offset match of a data address against a special register
  function automatic logic hit(input logic [8:0] a,
                               input logic [6:0] ofs);
    hit = (a[6:0] == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [4:0]  latch_q;
  logic [4:0]  latch_d;
  logic [7:0]  ptr_q;
  logic [7:0]  ptr_d;
  logic        bank_q;
  logic        bank_d;
  logic [7:0]  rdata_d;
  logic [12:0] pc_d;
  logic [2:0]  sp_q;
  logic [2:0]  sp_d;
  logic [12:0] stk_q [pcsia_pkg::STK_DEPTH];
  logic [12:0] stk_d [pcsia_pkg::STK_DEPTH];
  logic [7:0]  dmem  [pcsia_pkg::DMEM_WORDS];

  // decode results
  logic [8:0]  eff_addr;
  logic        self_ref;
  logic        sel_pcl;
  logic        sel_stat;
  logic        sel_ptr;
  logic        sel_lat;
  logic        sel_mem;
  logic        mem_we;
  logic        wr_pcl;
  logic [2:0]  sp_top;
  logic [2:0]  sp_up;
  // source code is declared straight from the package type, before any use
  pcsia_pkg::pcsia_src_t src;

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------

  // the window redirects through the pointer; a pointer aimed at the
  // window again is caught here so it can never loop
  always_comb begin : addr_decode
    eff_addr = reg_addr;
    if (is_window(reg_addr)) begin
      eff_addr = {bank_q, ptr_q};
    end
    self_ref = is_window(eff_addr);
    sel_pcl  = !self_ref && hit(eff_addr, pcsia_pkg::OFS_PC_LOW);
    sel_stat = !self_ref && hit(eff_addr, pcsia_pkg::OFS_STATUS);
    sel_ptr  = !self_ref && hit(eff_addr, pcsia_pkg::OFS_POINTER);
    sel_lat  = !self_ref && hit(eff_addr, pcsia_pkg::OFS_LATCH);
    sel_mem  = !self_ref && !sel_pcl && !sel_stat && !sel_ptr
               && !sel_lat;
    mem_we   = reg_wr && sel_mem;
    wr_pcl   = reg_wr && sel_pcl;
  end

  // ----------------------------------------------------------------
  // special registers and read path
  // ----------------------------------------------------------------

  // the latch only changes by a software write, never by the stack
  always_comb begin : regs_next
    latch_d = latch_q;
    ptr_d   = ptr_q;
    bank_d  = bank_q;
    rdata_d = reg_rdata_q;
    if (reg_wr && sel_lat) begin
      latch_d = reg_wdata[4:0];
    end
    if (reg_wr && sel_ptr) begin
      ptr_d = reg_wdata;
    end
    if (reg_wr && sel_stat) begin
      bank_d = reg_wdata[pcsia_pkg::BANK_BIT_POS];
    end
    if (reg_rd) begin
      if (self_ref) begin
        rdata_d = pcsia_pkg::WINDOW_RD;
      end else if (sel_pcl) begin
        rdata_d = pc_q[7:0];
      end else if (sel_lat) begin
        rdata_d = {3'h0, latch_q};
      end else if (sel_ptr) begin
        rdata_d = ptr_q;
      end else if (sel_stat) begin
        rdata_d = {bank_q, 7'h00};
      end else begin
        rdata_d = dmem[eff_addr];
      end
    end
  end

  // register the special registers and read data
  always_ff @(posedge clk) begin : regs_ff
    if (!reset_n) begin
      latch_q     <= pcsia_pkg::LATCH_RST;
      ptr_q       <= pcsia_pkg::PTR_RST;
      bank_q      <= pcsia_pkg::BANK_RST;
      reg_rdata_q <= pcsia_pkg::RDATA_RST;
    end else begin
      latch_q     <= latch_d;
      ptr_q       <= ptr_d;
      bank_q      <= bank_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // data file storage; contents are undefined after reset, as in ram
  always_ff @(posedge clk) begin : dmem_ff
    if (mem_we) begin
      dmem[eff_addr] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // program counter source
  // ----------------------------------------------------------------

  // one source per cycle: interrupt, return, branch, low byte write,
  // then plain fetch; the decoder never stacks two of the first four
  always_comb begin : src_sel
    if (int_req) begin
      src = pcsia_pkg::PCS_VECTOR;
    end else if (ret_req) begin
      src = pcsia_pkg::PCS_POP;
    end else if (call_req || jump_req) begin
      src = pcsia_pkg::PCS_PAGE;
    end else if (wr_pcl) begin
      src = pcsia_pkg::PCS_LOWWR;
    end else if (fetch) begin
      src = pcsia_pkg::PCS_NEXT;
    end else begin
      src = pcsia_pkg::PCS_HOLD;
    end
  end

  // ----------------------------------------------------------------
  // program counter and return stack
  // ----------------------------------------------------------------

  // the stack pointer is a bare 3-bit counter: it wraps silently in
  // both directions, so no overflow or underflow is ever reported
  always_comb begin : seq_next
    stk_d  = stk_q;
    sp_top = sp_q - pcsia_pkg::SP_STEP;
    sp_up  = sp_q + pcsia_pkg::SP_STEP;
    sp_d   = sp_q;
    pc_d   = pc_q;
    unique case (src)
      pcsia_pkg::PCS_VECTOR: begin
        stk_d[sp_q] = pc_q;
        sp_d        = sp_up;
        pc_d        = int_vector;
      end
      pcsia_pkg::PCS_POP: begin
        sp_d = sp_top;
        pc_d = stk_q[sp_top];
      end
      pcsia_pkg::PCS_PAGE: begin
        if (call_req) begin
          stk_d[sp_q] = pc_q;
          sp_d        = sp_up;
        end
        pc_d = {latch_q[pcsia_pkg::PAGE_HI_POS:pcsia_pkg::PAGE_LO_POS],
                branch_target};
      end
      pcsia_pkg::PCS_LOWWR: begin
        pc_d = {latch_q, reg_wdata};
      end
      pcsia_pkg::PCS_NEXT: begin
        pc_d = pc_q + pcsia_pkg::PC_STEP;
      end
      pcsia_pkg::PCS_HOLD: begin
        pc_d = pc_q;
      end
    endcase
  end

  // register the counter, pointer and stack entries
  always_ff @(posedge clk) begin : seq_ff
    if (!reset_n) begin
      pc_q <= pcsia_pkg::PC_RST;
      sp_q <= pcsia_pkg::SP_RST;
      for (int i = 0; i < pcsia_pkg::STK_DEPTH; i++) begin
        stk_q[i] <= pcsia_pkg::PC_RST;
      end
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
      for (int i = 0; i < pcsia_pkg::STK_DEPTH; i++) begin
        stk_q[i] <= stk_d[i];
      end
    end
  end

endmodule : pcsia_core

`default_nettype wire

// [hdl/pcsia_pkg.sv]
// pcsia_pkg: widths, register offsets, reset values and the program
// counter source codes shared by the sequencing and addressing core.
// assumes one instruction clock and a synchronous active-low reset.
`default_nettype none

package pcsia_pkg;

  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int PC_W       = 13;
  localparam int BYTE_W     = 8;
  localparam int LATCH_W    = 5;
  localparam int PAGE_OFS_W = 11;
  localparam int STK_DEPTH  = 8;
  localparam int SP_W       = 3;
  localparam int DADDR_W    = 9;
  localparam int DMEM_WORDS = 512;
  localparam int REG_OFS_W  = 7;

  // ----------------------------------------------------------------
  // register offsets inside each data bank (mirrored in every bank)
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_WINDOW  = 7'h00;
  localparam logic [6:0] OFS_PC_LOW  = 7'h02;
  localparam logic [6:0] OFS_STATUS  = 7'h03;
  localparam logic [6:0] OFS_POINTER = 7'h04;
  localparam logic [6:0] OFS_LATCH   = 7'h0A;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BANK_BIT_POS = 7;
  localparam int PAGE_HI_POS  = 4;
  localparam int PAGE_LO_POS  = 3;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [12:0] PC_RST    = 13'h0000;
  localparam logic [4:0]  LATCH_RST = 5'h00;
  localparam logic [7:0]  PTR_RST   = 8'h00;
  localparam logic        BANK_RST  = 1'b0;
  localparam logic [2:0]  SP_RST    = 3'h0;
  localparam logic [7:0]  RDATA_RST = 8'h00;
  localparam logic [7:0]  WINDOW_RD = 8'h00;
  localparam logic [12:0] PC_STEP   = 13'h0001;
  localparam logic [2:0]  SP_STEP   = 3'h1;

  // ----------------------------------------------------------------
  // where the next program counter comes from
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PCS_HOLD   = 3'b000,
    PCS_NEXT   = 3'b001,
    PCS_VECTOR = 3'b010,
    PCS_POP    = 3'b011,
    PCS_PAGE   = 3'b100,
    PCS_LOWWR  = 3'b101
  } pcsia_src_t;

endpackage : pcsia_pkg

`default_nettype wire

// [test/pcsia_props.sv]
// pcsia_props: port checks on program counter, stack and read path.
// bound to pcsia_core by the bench; sees only the core's ports.
`default_nettype none
module pcsia_props (
  // clock, reset and requests
  input wire logic        clk, reset_n, fetch, jump_req, call_req, ret_req, int_req,
  input wire logic [10:0] branch_target,
  input wire logic [12:0] int_vector,
  // register port and counter
  input wire logic [8:0]  reg_addr,
  input wire logic [7:0]  reg_wdata, reg_rdata_q,
  input wire logic        reg_wr, reg_rd,
  input wire logic [12:0] pc_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] lat_q;
  logic       idle;
  // latch shadow; indirect writes are not followed, the bench makes none
  always_ff @(posedge clk)
    if (!reset_n) lat_q <= 5'h00;
    else if (reg_wr && reg_addr[6:0] == 7'h0A) lat_q <= reg_wdata[4:0];
  assign idle = !(jump_req || call_req || ret_req || int_req);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // each check ties the counter or read data to its cause
  AST_RST_CLR: assert property ($rose(reset_n) |-> pc_q == 13'h0000)
    else $error("pc not cleared");
  AST_FETCH: assert property (fetch && idle && !reg_wr |=>
    pc_q == $past(pc_q) + 13'h0001) else $error("no step");
  AST_JUMP: assert property (jump_req && !call_req && !ret_req && !int_req |=>
    pc_q == {$past(lat_q[4:3]), $past(branch_target)}) else $error("bad jump");
  AST_INT: assert property (int_req |=> pc_q == $past(int_vector))
    else $error("bad vector");
  AST_CALL_RET: assert property (call_req && !ret_req && !int_req ##1 ret_req && !int_req
    |=> pc_q == $past(pc_q, 2)) else $error("bad return");
  AST_INT_RET: assert property (int_req ##1 ret_req && !int_req |=>
    pc_q == $past(pc_q, 2)) else $error("bad interrupt return");
  AST_LOW_WR: assert property (reg_wr && reg_addr[6:0] == 7'h02 && idle |=>
    pc_q == {$past(lat_q), $past(reg_wdata)}) else $error("bad low write");
  AST_PCL_RD: assert property (reg_rd && reg_addr[6:0] == 7'h02 |=>
    reg_rdata_q == $past(pc_q[7:0])) else $error("bad low read");
endmodule : pcsia_props
`default_nettype wire

// [test/pcsia_seq_model.sv]
// pcsia_seq_model: stand-in for the decoder and interrupt logic.
// assumes the bench holds op and arg for one cycle per request.
`default_nettype none
module pcsia_seq_model (
  // command from the bench
  input  wire logic [2:0]  op,
  input  wire logic [12:0] arg,
  // requests to the core
  output logic             fetch, jump_req, call_req, ret_req, int_req,
  output logic [10:0]      branch_target,
  output logic [12:0]      int_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  // one request per op; idle operands carry inverted junk, never a hint
  assign fetch         = (op == 3'h1);
  assign jump_req      = (op == 3'h2);
  assign call_req      = (op == 3'h3);
  assign ret_req       = (op == 3'h4);
  assign int_req       = (op == 3'h5);
  assign branch_target = (jump_req || call_req) ? arg[10:0] : ~arg[10:0];
  assign int_vector    = int_req ? arg : ~arg;
endmodule : pcsia_seq_model
`default_nettype wire

// [test/tb_pc_stack_indirect_addressing.sv]
// tb_pc_stack_indirect_addressing: self-checking bench of pcsia_core.
// assumes the decoder model as request source and a 125 MHz clock.
`default_nettype none
module tb_pc_stack_indirect_addressing;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        fetch, jump_req, call_req, ret_req, int_req;
  logic [2:0]  op = 3'h0;
  logic [12:0] arg = 13'h0000, int_vector, pc_q;
  logic [10:0] branch_target;
  logic [8:0]  reg_addr = 9'h000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata_q;
  int          bad_count = 0, comparisons = 0, cycles = 0;
  // 8 ns period
  always #4 clk = ~clk;
  // request source and the core
  pcsia_seq_model i_seq (.op(op), .arg(arg), .fetch(fetch), .jump_req(jump_req),
    .call_req(call_req), .ret_req(ret_req), .int_req(int_req),
    .branch_target(branch_target), .int_vector(int_vector));
  pcsia_core i_dut (.clk(clk), .reset_n(reset_n), .fetch(fetch), .jump_req(jump_req),
    .call_req(call_req), .ret_req(ret_req), .int_req(int_req),
    .branch_target(branch_target), .int_vector(int_vector), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .pc_q(pc_q));
  // case inequality, so an unknown never passes
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  // request held one cycle, taken at the next edge; op 0 idles
  task automatic do_op(input logic [2:0] c, input logic [12:0] a);
    @(posedge clk);
    op <= c;
    arg <= a;
  endtask : do_op
  // idle one edge so the last request lands
  task automatic pc_is(input logic [12:0] e);
    do_op(3'h0, 13'h0000);
    #1 chk(pc_q, e);
  endtask : pc_is
  // one register cycle; read data judged in the cycle after the strobe
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 if (!w) chk({5'h00, reg_rdata_q}, {5'h00, d});
  endtask : acc
  // reset value, latch width, top-page jump, 13-bit wrap
  task automatic t_fetch;
    pc_is(13'h0000);
    acc(1'b1, 9'h08A, 8'hFF); // page bits set before the jump
    acc(1'b0, 9'h00A, 8'h1F);
    do_op(3'h2, 13'h07FF);
    pc_is(13'h1FFF);
    do_op(3'h1, 13'h0000);
    do_op(3'h1, 13'h0000);
    pc_is(13'h0001);
  endtask : t_fetch
  // ten calls overrun eight entries; ten returns show the overwrite
  task automatic t_stack;
    acc(1'b1, 9'h00A, 8'h0B); // calls land in page 1
    do_op(3'h2, 13'h0000);
    pc_is(13'h0800);
    for (int i = 0; i < 10; i++)
      do_op(3'h3, 13'h0100 + 13'(i));
    for (int j = 0; j < 10; j++) begin
      do_op(3'h4, 13'h0000);
      pc_is(13'h0908 - 13'(j % 8));
    end
    acc(1'b1, 9'h002, 8'h55); // computed jump takes its upper five bits from the latch, not from the old counter
    pc_is(13'h0B55);
    acc(1'b0, 9'h102, 8'h55);
  endtask : t_stack
  // interrupt round trip, then a reset in mid-run
  task automatic t_int;
    do_op(3'h5, 13'h0004);
    do_op(3'h4, 13'h0000);
    pc_is(13'h0B55);
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    #1 chk(pc_q, 13'h0000);
  endtask : t_int
  // window access, bank bit on top, window aimed at itself
  task automatic t_ind;
    acc(1'b1, 9'h020, 8'h33);
    acc(1'b1, 9'h004, 8'h20);
    acc(1'b1, 9'h083, 8'h80);
    acc(1'b1, 9'h000, 8'h5A);
    acc(1'b0, 9'h120, 8'h5A);
    acc(1'b0, 9'h020, 8'h33);
    acc(1'b1, 9'h004, 8'h80);
    acc(1'b1, 9'h100, 8'h77);
    acc(1'b0, 9'h000, 8'h00);
    acc(1'b0, 9'h004, 8'h80);
    acc(1'b0, 9'h120, 8'h5A); // self-aimed write left earlier target alone
  endtask : t_ind
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_fetch;
    t_stack;
    t_int;
    t_ind;
    final_report;
  end
  // hang guard; the run needs under a hundred cycles
  always @(posedge clk)
    if (++cycles == 5000) begin
      bad_count++;
      final_report;
    end
endmodule : tb_pc_stack_indirect_addressing
bind pcsia_core pcsia_props i_props (.clk(clk), .reset_n(reset_n), .fetch(fetch),
  .jump_req(jump_req), .call_req(call_req), .ret_req(ret_req), .int_req(int_req),
  .branch_target(branch_target), .int_vector(int_vector), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .pc_q(pc_q));
`default_nettype wire
